//--- dv/internal_data_memory_decoder_test.sv
/*
 * Self-checking bench for the data memory decoder.
 * Assumes the SFR and code model answers the far side.
 */
`timescale 1ns/1ps
`default_nettype none

module internal_data_memory_decoder_test;
	import memdec_pkg::*;
	logic clk = 0, arst_n = 0, vld = 0, wr = 0, wb = 0, rdy, rv, rb, re;
	logic [2:0] md = 0;
	logic [15:0] ad = 0, ca;
	logic [7:0] wd = 0, rd, sa, sw, sr, cr, r, ba, ram [256], sfr [256];
	logic [19:0] pi = 0, po, oe, pu = 0;
	logic sr_s, sw_s, cr_s;
	logic [11:0] exp_q [$];
	logic [11:0] e;
	int miscompares = 0, cmp_count = 0, cyc = 0;
	int a, i;

	always #10 clk = ~clk;

	internal_data_memory_decoder dut (.CLK_I(clk), .ARST_N_I(arst_n),
		.REQ_VALID_I(vld), .REQ_READY_O(rdy), .REQ_MODE_I(md), .REQ_WRITE_I(wr),
		.REQ_ADDR_I(ad), .REQ_WDATA_I(wd), .REQ_WBIT_I(wb), .RESP_VALID_O(rv),
		.RESP_DATA_O(rd), .RESP_BIT_O(rb), .RESP_ERR_O(re), .SFR_RD_O(sr_s),
		.SFR_WE_O(sw_s), .SFR_ADDR_O(sa), .SFR_WDATA_O(sw), .SFR_RDATA_I(sr),
		.CODE_RD_O(cr_s), .CODE_ADDR_O(ca), .CODE_RDATA_I(cr), .PIN_I(pi),
		.PIN_O(po), .PIN_OE_O(oe), .PULLUP_EN_I(pu));

	sfr_code_model far (.clk_i(clk), .sfr_rd_i(sr_s), .sfr_we_i(sw_s),
		.sfr_addr_i(sa), .sfr_wdata_i(sw), .sfr_rdata_o(sr), .code_rd_i(cr_s),
		.code_addr_i(ca), .code_rdata_o(cr));

	task automatic chk(input string n, input logic [19:0] s, input logic [19:0] x);
		cmp_count++;
		if (s !== x) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================
	// One request, expectation {chkdata, err, chkbit, bit, data}
	task automatic acc(input logic [2:0] m, input logic w, input logic [15:0] x,
		input logic [7:0] d, input logic b, input logic [11:0] ex);
		int n;
		exp_q.push_back(ex);
		vld <= 1;
		md <= m;
		wr <= w;
		ad <= x;
		wd <= d;
		wb <= b;
		@(negedge clk);
		while (rdy !== 1'b1) @(negedge clk);
		@(posedge clk);
		vld <= 0;
		n = 0;
		while (rv !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
	endtask

	// ==========================================
	// Response monitor
	always @(negedge clk) begin
		if (rv === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("spare", 1, 0);
			end else begin
				e = exp_q.pop_front();
				chk("err", re, e[10]);
				if (e[11]) chk("data", rd, e[7:0]);
				if (e[9]) chk("bit", rb, e[8]);
			end
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	initial begin
		void'($urandom(32'hf2bf));
		repeat (10) @(posedge clk);
		chk("pin rst", po, PORT_RST);
		arst_n <= 1;
		pu <= $urandom;
		repeat (3) @(posedge clk);
		for (i = 0; i < 48; i++) begin
			a = (i < 16) ? 32 + i : $urandom % 128;
			r = $urandom;
			ram[a] = r;
			acc(MODE_DIRECT, 1, a, r, 0, 0);
			if (i >= 16) acc(MODE_INDIRECT, 0, a, 0, 0, {4'h8, r});
		end
		for (i = 0; i < 5; i++) begin
			a = (i == 4) ? 8'h87 : 8'hc1 + 8 * i;
			ram[a] = $urandom;
			sfr[a] = $urandom;
			acc(MODE_INDIRECT, 1, a, ram[a], 0, 0);
			acc(MODE_DIRECT, 1, a, sfr[a], 0, 0);
			acc(MODE_INDIRECT, 0, a, 0, 0, {4'h8, ram[a]});
			acc(MODE_DIRECT, 0, a, 0, 0, {4'h8, sfr[a]});
		end
		for (i = 0; i < 24; i++) begin
			a = (i < 2) ? 127 * i : $urandom % 128;
			ba = 8'h20 + a[6:3];
			ram[ba][a[2:0]] = $urandom;
			acc(MODE_BIT, 1, a, 0, ram[ba][a[2:0]], {4'ha, ram[ba]} | (ram[ba][a[2:0]] << 8));
			acc(MODE_BIT, 0, a, 0, 0, {4'h2, 8'h0} | (ram[ba][a[2:0]] << 8));
			acc(MODE_DIRECT, 0, ba, 0, 0, {4'h8, ram[ba]});
		end
		acc(MODE_EXT, 1, 0, 8'h5a, 0, 0);
		acc(MODE_EXT, 1, EXT_RAM_TOP, 8'ha5, 0, 0);
		acc(MODE_EXT, 0, 0, 0, 0, 12'h85a);
		acc(MODE_EXT, 0, EXT_RAM_TOP, 0, 0, 12'h8a5);
		acc(MODE_EXT, 1, 16'h0800, 1, 0, 12'h400);
		acc(MODE_EXT, 0, 16'h0800, 0, 0, 12'hc00);
		acc(MODE_CODE, 0, CODE_TOP, 0, 0, {4'h8, 8'hf7 ^ 8'hff});
		acc(MODE_CODE, 0, 16'hf800, 0, 0, 12'hc00);
		acc(MODE_CODE, 1, 16'h0010, 1, 0, 12'h400);
		for (i = 5; i < 8; i++) acc(i, 0, 0, 0, 0, 12'hc00);
		// bit write on an SFR row
		r = $urandom;
		acc(MODE_DIRECT, 1, 16'h00b8, r, 0, 0);
		r[3] = ~r[3];
		acc(MODE_BIT, 1, 16'h00bb, 0, r[3], {3'h5, r[3], r});
		acc(MODE_DIRECT, 0, 16'h00b8, 0, 0, {4'h8, r});
		r = $urandom;
		acc(MODE_DIRECT, 1, PORT1_ADDR, r, 0, 0);
		acc(MODE_DIRECT, 1, PORT2_ADDR, r, 0, 0);
		acc(MODE_BIT, 1, PORT0_ADDR + 3, 0, 0, 12'ha00 | 8'hf7);
		repeat (3) @(posedge clk);
		chk("pin_o", po, {r[3:0], r, 8'hf7});
		chk("pin_oe", oe, ~{r[3:0], r, 8'hf7} | pu);
		pi <= $urandom;
		repeat (4) @(posedge clk);
		acc(MODE_DIRECT, 0, PORT0_ADDR, 0, 0, {4'h8, pi[7:0]});
		acc(MODE_DIRECT, 0, PORT2_ADDR, 0, 0, {8'h80, pi[19:16]});
		acc(MODE_BIT, 0, PORT1_ADDR + 5, 0, 0, {3'h1, pi[13], 8'h0});
		repeat (5) @(posedge clk);
		chk("queue", exp_q.size(), 0);
		finish_test();
	end
endmodule

`default_nettype wire

//--- dv/sfr_code_model.sv
/*
 * Model of the SFR space and on-chip code store beside the decoder.
 * Assumes strobes and addresses change on the rising edge of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module sfr_code_model (
	input  wire logic        clk_i,
	input  wire logic        sfr_rd_i,
	input  wire logic        sfr_we_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	input  wire logic        code_rd_i,
	input  wire logic [15:0] code_addr_i,
	output logic      [7:0]  code_rdata_o
);
	logic [7:0] regs [256];
	logic [7:0] cval;

	// ==========================================
	// Answers, garbage outside strobes
	always_comb begin
		cval = code_addr_i[15:8] ^ code_addr_i[7:0];
		sfr_rdata_o = sfr_rd_i ? regs[sfr_addr_i] : ~regs[sfr_addr_i];
		code_rdata_o = code_rd_i ? cval : ~cval;
	end

	always_ff @(posedge clk_i) begin
		if (sfr_we_i) begin
			regs[sfr_addr_i] <= sfr_wdata_i;
		end
	end
endmodule

`default_nettype wire

//--- hdl/byte_mem.sv
/*
 * Single-port byte memory with registered read data.
 * Assumes address and write strobe come from the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module byte_mem #(
	parameter int AW = 8
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [7:0]    wdata_i,
	output logic      [7:0]    rdata_o
);

	logic [7:0] mem_q [2**AW];
	logic [7:0] rdata_d;

	// ==========================================
	// Read path
	always_comb begin
		rdata_d = mem_q[addr_i];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rdata_d;
		end
	end

	// ==========================================
	// Array write
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[addr_i] <= wdata_i;
		end
	end

endmodule

`default_nettype wire

//--- hdl/internal_data_memory_decoder.sv
/*
 * Internal data memory decoder: general RAM, extended RAM, SFR routing,
 * bit access and the three general-purpose ports.
 * Assumes the core holds one request until REQ_READY_O and answers
 * SFR and code reads combinationally in the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module internal_data_memory_decoder (
	input  wire logic                           CLK_I,
	input  wire logic                           ARST_N_I,
	input  wire logic                           REQ_VALID_I,
	output logic                                REQ_READY_O,
	input  wire logic [2:0]                     REQ_MODE_I,
	input  wire logic                           REQ_WRITE_I,
	input  wire logic [15:0]                    REQ_ADDR_I,
	input  wire logic [7:0]                     REQ_WDATA_I,
	input  wire logic                           REQ_WBIT_I,
	output logic                                RESP_VALID_O,
	output logic [7:0]                          RESP_DATA_O,
	output logic                                RESP_BIT_O,
	output logic                                RESP_ERR_O,
	output logic                                SFR_RD_O,
	output logic                                SFR_WE_O,
	output logic [7:0]                          SFR_ADDR_O,
	output logic [7:0]                          SFR_WDATA_O,
	input  wire logic [7:0]                     SFR_RDATA_I,
	output logic                                CODE_RD_O,
	output logic [15:0]                         CODE_ADDR_O,
	input  wire logic [7:0]                     CODE_RDATA_I,
	input  wire logic [memdec_pkg::PIN_N-1:0]   PIN_I,
	output logic      [memdec_pkg::PIN_N-1:0]   PIN_O,
	output logic      [memdec_pkg::PIN_N-1:0]   PIN_OE_O,
	input  wire logic [memdec_pkg::PIN_N-1:0]   PULLUP_EN_I
);
	import memdec_pkg::*;

	logic                rst_meta_q;
	logic                rst_n;
	logic [PIN_N-1:0]    pin_meta_q;
	logic [PIN_N-1:0]    pin_sync_q;
	state_t              state_q,  state_d;
	target_t             tgt_q,    tgt_d;
	logic [15:0]         addr_q,   addr_d;
	logic [2:0]          bit_q,    bit_d;
	logic                is_bit_q, is_bit_d;
	logic                wr_q,     wr_d;
	logic [7:0]          wdata_q,  wdata_d;
	logic                wbit_q,   wbit_d;
	logic [7:0]          cap_q,    cap_d;
	logic [7:0]          rdata_q,  rdata_d;
	logic                rbit_q,   rbit_d;
	logic [PIN_N-1:0]    latch_q,  latch_d;
	logic [PIN_N-1:0]    oe_q,     oe_d;
	target_t             dec_tgt;
	logic [15:0]         dec_addr;
	logic [2:0]          dec_bit;
	logic [7:0]          a8;
	logic                accept;
	logic                wr_strobe;
	logic [7:0]          ram_rd;
	logic [7:0]          ext_rd;
	logic [7:0]          src_byte;
	logic [7:0]          merged;
	logic [7:0]          latch_byte;
	logic [7:0]          pin_byte;

	// ==========================================
	// Reset release and pin synchronisers
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= PIN_I;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ==========================================
	// Request decode
	assign a8     = REQ_ADDR_I[7:0];
	assign accept = REQ_VALID_I && REQ_READY_O;

	always_comb begin
		dec_tgt  = T_RAM;
		dec_addr = {8'h00, a8};
		dec_bit  = 3'h0;
		unique case (REQ_MODE_I)
			MODE_DIRECT: begin
				if (a8 >= SFR_BASE) begin
					if (a8 == PORT0_ADDR || a8 == PORT1_ADDR || a8 == PORT2_ADDR) begin
						dec_tgt = T_PORT;
					end else begin
						dec_tgt = T_SFR;
					end
				end
			end
			MODE_INDIRECT: begin
				dec_tgt = T_RAM;
			end
			MODE_BIT: begin
				dec_bit = a8[2:0];
				if (a8 < SFR_BASE) begin
					dec_addr = {8'h00, BIT_RAM_BASE + {4'h0, a8[6:3]}};
				end else begin
					dec_addr = {8'h00, a8[7:3], 3'h0};
					if (dec_addr[7:0] == PORT0_ADDR || dec_addr[7:0] == PORT1_ADDR
						|| dec_addr[7:0] == PORT2_ADDR) begin
						dec_tgt = T_PORT;
					end else if (dec_addr[7:0] == PWR_CTRL_ADDR) begin
						dec_tgt = T_ERR;
					end else begin
						dec_tgt = T_SFR;
					end
				end
			end
			MODE_EXT: begin
				dec_addr = REQ_ADDR_I;
				dec_tgt  = (REQ_ADDR_I > EXT_RAM_TOP) ? T_ERR : T_EXT_RAM;
			end
			MODE_CODE: begin
				dec_addr = REQ_ADDR_I;
				dec_tgt  = (REQ_WRITE_I || REQ_ADDR_I > CODE_TOP) ? T_ERR : T_CODE;
			end
			default: begin
				dec_tgt = T_ERR;
			end
		endcase
	end

	// ==========================================
	// Memories
	assign wr_strobe = (state_q == S_ACC && wr_q && !is_bit_q) || state_q == S_WB;

	byte_mem #(.AW(RAM_AW)) u_gp_ram (
		.clk_i   (CLK_I),
		.rst_n_i (rst_n),
		.we_i    (wr_strobe && tgt_q == T_RAM),
		.addr_i  (addr_q[RAM_AW-1:0]),
		.wdata_i (wdata_q),
		.rdata_o (ram_rd)
	);

	byte_mem #(.AW(EXT_RAM_AW)) u_extended_internal_ram (
		.clk_i   (CLK_I),
		.rst_n_i (rst_n),
		.we_i    (wr_strobe && tgt_q == T_EXT_RAM),
		.addr_i  (addr_q[EXT_RAM_AW-1:0]),
		.wdata_i (wdata_q),
		.rdata_o (ext_rd)
	);

	// ==========================================
	// Port byte views
	// Three ports, twenty pins
	always_comb begin
		if (addr_q[7:0] == PORT0_ADDR) begin
			latch_byte = latch_q[7:0];
			pin_byte   = pin_sync_q[7:0];
		end else if (addr_q[7:0] == PORT1_ADDR) begin
			latch_byte = latch_q[15:8];
			pin_byte   = pin_sync_q[15:8];
		end else begin
			latch_byte = {4'h0, latch_q[19:16]};
			pin_byte   = {4'h0, pin_sync_q[19:16]};
		end
	end

	always_comb begin
		unique case (tgt_q)
			T_RAM:   src_byte = ram_rd;
			T_EXT_RAM: src_byte = ext_rd;
			T_ERR:   src_byte = 8'h00;
			default: src_byte = cap_q;
		endcase
		merged         = (tgt_q == T_PORT) ? latch_byte : src_byte;
		merged[bit_q]  = wbit_q;
	end

	// ==========================================
	// Sequencer next state
	always_comb begin
		state_d  = state_q;
		tgt_d    = tgt_q;
		addr_d   = addr_q;
		bit_d    = bit_q;
		is_bit_d = is_bit_q;
		wr_d     = wr_q;
		wdata_d  = wdata_q;
		wbit_d   = wbit_q;
		cap_d    = cap_q;
		rdata_d  = rdata_q;
		rbit_d   = rbit_q;
		latch_d  = latch_q;
		unique case (state_q)
			S_IDLE: begin
				if (REQ_VALID_I) begin
					state_d  = S_ACC;
					tgt_d    = dec_tgt;
					addr_d   = dec_addr;
					bit_d    = dec_bit;
					is_bit_d = (REQ_MODE_I == MODE_BIT);
					wr_d     = REQ_WRITE_I;
					wdata_d  = REQ_WDATA_I;
					wbit_d   = REQ_WBIT_I;
				end
			end
			S_ACC: begin
				state_d = S_FETCH;
				unique case (tgt_q)
					T_SFR:   cap_d = SFR_RDATA_I;
					T_CODE:  cap_d = CODE_RDATA_I;
					T_PORT:  cap_d = pin_byte;
					default: cap_d = 8'h00;
				endcase
			end
			S_FETCH: begin
				rdata_d = src_byte;
				rbit_d  = src_byte[bit_q];
				if (wr_q && is_bit_q && tgt_q != T_ERR) begin
					wdata_d = merged;
					rdata_d = merged;
					rbit_d  = wbit_q;
					state_d = S_WB;
				end else begin
					state_d = S_RESP;
				end
			end
			S_WB: begin
				state_d = S_RESP;
			end
			S_RESP: begin
				state_d = S_IDLE;
			end
		endcase
		if (wr_strobe && tgt_q == T_PORT) begin
			if (addr_q[7:0] == PORT0_ADDR) begin
				latch_d[7:0] = wdata_q;
			end else if (addr_q[7:0] == PORT1_ADDR) begin
				latch_d[15:8] = wdata_q;
			end else begin
				latch_d[19:16] = wdata_q[3:0];
			end
		end
		oe_d = ~latch_d | PULLUP_EN_I;
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= S_IDLE;
			tgt_q    <= T_RAM;
			addr_q   <= 16'h0000;
			bit_q    <= 3'h0;
			is_bit_q <= 1'b0;
			wr_q     <= 1'b0;
			wdata_q  <= DATA_RST;
			wbit_q   <= 1'b0;
			cap_q    <= DATA_RST;
			rdata_q  <= DATA_RST;
			rbit_q   <= 1'b0;
			latch_q  <= PORT_RST;
			oe_q     <= '0;
		end else begin
			state_q  <= state_d;
			tgt_q    <= tgt_d;
			addr_q   <= addr_d;
			bit_q    <= bit_d;
			is_bit_q <= is_bit_d;
			wr_q     <= wr_d;
			wdata_q  <= wdata_d;
			wbit_q   <= wbit_d;
			cap_q    <= cap_d;
			rdata_q  <= rdata_d;
			rbit_q   <= rbit_d;
			latch_q  <= latch_d;
			oe_q     <= oe_d;
		end
	end

	// ==========================================
	// Outputs
	assign REQ_READY_O  = (state_q == S_IDLE);
	assign RESP_VALID_O = (state_q == S_RESP);
	assign RESP_ERR_O   = (state_q == S_RESP) && (tgt_q == T_ERR);
	assign RESP_DATA_O  = rdata_q;
	assign RESP_BIT_O   = rbit_q;
	assign SFR_RD_O     = (state_q == S_ACC) && (tgt_q == T_SFR) && (!wr_q || is_bit_q);
	assign SFR_WE_O     = wr_strobe && (tgt_q == T_SFR);
	assign SFR_ADDR_O   = addr_q[7:0];
	assign SFR_WDATA_O  = wdata_q;
	assign CODE_RD_O    = (state_q == S_ACC) && (tgt_q == T_CODE);
	assign CODE_ADDR_O  = addr_q;
	assign PIN_O        = latch_q;
	assign PIN_OE_O     = oe_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!rst_n);

	chk_direct_low_ram: assert property (
		accept && REQ_MODE_I == MODE_DIRECT && a8 < SFR_BASE
		|=> tgt_q == T_RAM && addr_q[7:0] == $past(a8))
		else $error("direct low access not routed to RAM");

	chk_indirect_high: assert property (
		accept && REQ_MODE_I == MODE_INDIRECT && a8 >= SFR_BASE
		|=> tgt_q == T_RAM && !SFR_RD_O && !SFR_WE_O)
		else $error("indirect high access left RAM");

	chk_direct_high_sfr: assert property (
		accept && REQ_MODE_I == MODE_DIRECT && !REQ_WRITE_I && a8 >= SFR_BASE
		&& a8 != PORT0_ADDR && a8 != PORT1_ADDR && a8 != PORT2_ADDR
		|=> SFR_RD_O && SFR_ADDR_O == $past(a8))
		else $error("direct high read missed SFR space");

	chk_bit_ram_map: assert property (
		accept && REQ_MODE_I == MODE_BIT && a8 < SFR_BASE
		|=> addr_q[7:0] == BIT_RAM_BASE + {4'h0, $past(a8[6:3])}
		&& bit_q == $past(a8[2:0]))
		else $error("bit address mapped to wrong RAM bit");

	chk_resp_latency: assert property (
		accept |-> ##[3:4] RESP_VALID_O)
		else $error("response not within four cycles");

	chk_extended_internal_ram_bound: assert property (
		accept && REQ_MODE_I == MODE_EXT && REQ_ADDR_I > EXT_RAM_TOP
		|-> ##3 RESP_VALID_O && RESP_ERR_O)
		else $error("extended access beyond 2 kB not refused");

	chk_code_no_write: assert property (
		accept && REQ_MODE_I == MODE_CODE && REQ_WRITE_I
		|-> ##3 RESP_ERR_O)
		else $error("code space write not refused");

	chk_pin_open_drain: assert property (
		(PIN_OE_O & PIN_O & ~$past(PULLUP_EN_I)) == '0)
		else $error("pin driven high without pull-up");

	chk_pwr_ctrl_bit: assert property (
		SFR_WE_O && SFR_ADDR_O == PWR_CTRL_ADDR |-> !is_bit_q)
		else $error("bit write reached power control register");

	chk_bit_rmw_one: assert property (
		state_q == S_WB && tgt_q == T_RAM
		|-> (((wdata_q ^ ram_rd) & ~(8'h01 << bit_q)) == 8'h00)
		&& wdata_q[bit_q] == wbit_q)
		else $error("bit write changed other bits");

endmodule

`default_nettype wire

//--- hdl/memdec_pkg.sv
/*
 * Constants and types for the internal data memory decoder.
 * Assumes one core clock and that the decoder and its memories share it.
 */
package memdec_pkg;

	// ==========================================
	// Access modes presented by the core
	localparam logic [2:0]  MODE_DIRECT   = 3'h0;
	localparam logic [2:0]  MODE_INDIRECT = 3'h1;
	localparam logic [2:0]  MODE_BIT      = 3'h2;
	localparam logic [2:0]  MODE_EXT      = 3'h3;
	localparam logic [2:0]  MODE_CODE     = 3'h4;

	// ==========================================
	// Memory sizes and address map
	localparam int          RAM_AW        = 8;
	localparam int          EXT_RAM_AW    = 11;
	localparam logic [7:0]  SFR_BASE      = 8'h80;
	localparam logic [7:0]  BIT_RAM_BASE  = 8'h20;
	localparam logic [15:0] EXT_RAM_TOP   = 16'h07ff;
	localparam logic [15:0] CODE_TOP      = 16'hf7ff;

	// ==========================================
	// Special function register addresses
	localparam logic [7:0]  PWR_CTRL_ADDR = 8'h87;
	localparam logic [7:0]  PORT0_ADDR    = 8'h80;
	localparam logic [7:0]  PORT1_ADDR    = 8'h90;
	localparam logic [7:0]  PORT2_ADDR    = 8'ha0;

	// ==========================================
	// Port pins and reset values
	localparam int          PIN_N         = 20;
	localparam logic [19:0] PORT_RST      = 20'hfffff;
	localparam logic [7:0]  DATA_RST      = 8'h00;

	// ==========================================
	// Types
	typedef enum logic [2:0] {
		T_RAM, T_SFR, T_PORT, T_EXT_RAM, T_CODE, T_ERR
	} target_t;

	typedef enum logic [2:0] {
		S_IDLE, S_ACC, S_FETCH, S_WB, S_RESP
	} state_t;

endpackage
